// ### core/frx_pkg.sv
// Constants and types shared by the file-register execute block
package frx_pkg;

  // ***************************************************************
  // Widths
  // ***************************************************************
  localparam int unsigned FRX_DATA_W  = 8;
  localparam int unsigned FRX_INSTR_W = 12;
  localparam int unsigned FRX_ADDR_W  = 5;
  localparam int unsigned FRX_PC_W    = 11;
  localparam int unsigned FRX_BR_W    = 9;
  localparam int unsigned FRX_PAGE_W  = 2;

  // ***************************************************************
  // Instruction fields
  // ***************************************************************
  localparam int unsigned FRX_F_LSB    = 0;
  localparam int unsigned FRX_F_MSB    = 4;
  localparam int unsigned FRX_DEST_BIT = 5;
  localparam int unsigned FRX_K_MSB    = 7;
  localparam int unsigned FRX_BR_MSB   = 8;
  localparam int unsigned FRX_OP6_LSB  = 6;
  localparam int unsigned FRX_OP4_LSB  = 8;
  localparam int unsigned FRX_OP3_LSB  = 9;

  // Opcode patterns, matched on the upper instruction bits
  localparam logic [5:0] FRX_OP_COMPLEMENT = 6'h09;
  localparam logic [5:0] FRX_OP_DECREMENT  = 6'h03;
  localparam logic [5:0] FRX_OP_DEC_SKIP   = 6'h0B;
  localparam logic [5:0] FRX_OP_INCREMENT  = 6'h0A;
  localparam logic [5:0] FRX_OP_INC_SKIP   = 6'h0F;
  localparam logic [5:0] FRX_OP_OR_REG     = 6'h04;
  localparam logic [3:0] FRX_OP_OR_LIT     = 4'hD;
  localparam logic [2:0] FRX_OP_BRANCH     = 3'h5;

  // ***************************************************************
  // Reset values and constants
  // ***************************************************************
  localparam logic [FRX_DATA_W-1:0] FRX_ACC_RST  = 8'h00;
  localparam logic [FRX_DATA_W-1:0] FRX_ONE      = 8'h01;
  localparam logic [FRX_DATA_W-1:0] FRX_ZERO     = 8'h00;
  localparam logic                  FRX_DEST_ACC = 1'b0;

  // ***************************************************************
  // Execution state
  // ***************************************************************
  typedef enum logic [0:0] {
    FRX_ST_RUN   = 1'b0,
    FRX_ST_FLUSH = 1'b1
  } frx_state_e;

endpackage

// ### core/frx_exec.sv
// Execute stage for complement, inc/dec (with skip), OR and branch instructions
`timescale 1ns/10ps

// Summary of operation
// - A destination bit of zero sends the result to the accumulator, one sends it back to file register 0 to 31.
// - Complement inverts the file register, routes by destination bit and updates the zero flag.
// - Decrement subtracts one from the file register, routes by destination bit and updates the zero flag.
// - Decrement-and-skip subtracts one, routes by destination bit and leaves the flags alone.
// - A zero decrement-and-skip result turns the prefetched next instruction into a no-operation.
// - Increment adds one to the file register, routes by destination bit and updates the zero flag.
// - Increment-and-skip adds one, routes by destination bit and leaves the flags alone.
// - A zero increment-and-skip result turns the prefetched next instruction into a no-operation.
// - Branch loads its 9-bit immediate into counter bits 8:0 and page bits 6:5 into counter bits 10:9.
// - Branch is always taken, leaves flags alone and takes two cycles.
// - OR-with-literal ORs the accumulator with an 8-bit literal into the accumulator and updates zero.
// - OR-with-register ORs accumulator with file register, routes by destination bit, updates zero.
module frx_exec
  import frx_pkg::*;
#(
  parameter int unsigned DATA_W = FRX_DATA_W
) (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire logic                  instr_valid,
  input  wire logic [FRX_INSTR_W-1:0] instr,
  input  wire logic [DATA_W-1:0]     file_rdata,
  input  wire logic [FRX_PAGE_W-1:0] status_page,
  output logic      [DATA_W-1:0]     acc_reg,
  output logic                       zero_reg,
  output logic                       file_we_reg,
  output logic      [FRX_ADDR_W-1:0] file_addr_reg,
  output logic      [DATA_W-1:0]     file_wdata_reg,
  output logic                       pc_load_reg,
  output logic      [FRX_PC_W-1:0]   pc_target_reg,
  output logic                       squash_reg
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  // Opcodes carry an 8-bit literal and the zero flag is an 8-bit test
  if (DATA_W != FRX_DATA_W) begin : g_bad_width
    $error("frx_exec: DATA_W must equal 8");
  end

  // The field positions below must tile the instruction word without gaps
  if (FRX_F_MSB - FRX_F_LSB + 1 != FRX_ADDR_W) begin : g_bad_faddr
    $error("frx_exec: file address field does not match FRX_ADDR_W");
  end

  if (FRX_K_MSB + 1 != DATA_W) begin : g_bad_literal
    $error("frx_exec: literal field does not match DATA_W");
  end

  if (FRX_BR_MSB + 1 != FRX_BR_W) begin : g_bad_br_field
    $error("frx_exec: branch field does not match FRX_BR_W");
  end

  if (FRX_BR_W + FRX_PAGE_W != FRX_PC_W) begin : g_bad_pc_width
    $error("frx_exec: branch target does not fill the program counter");
  end

  if (FRX_INSTR_W - FRX_OP6_LSB != 6) begin : g_bad_op6
    $error("frx_exec: six-bit opcode field misplaced");
  end

  if (FRX_INSTR_W - FRX_OP4_LSB != 4) begin : g_bad_op4
    $error("frx_exec: four-bit opcode field misplaced");
  end

  if (FRX_INSTR_W - FRX_OP3_LSB != 3) begin : g_bad_op3
    $error("frx_exec: three-bit opcode field misplaced");
  end

  if (FRX_DEST_BIT <= FRX_F_MSB || FRX_DEST_BIT >= FRX_OP6_LSB) begin : g_bad_dest
    $error("frx_exec: destination bit overlaps another field");
  end

  // The branch and OR-literal opcodes must not alias, or one word would decode twice
  if (FRX_OP_BRANCH == FRX_OP_OR_LIT[3:1]) begin : g_bad_alias
    $error("frx_exec: branch and OR-literal opcodes alias");
  end

  // ***************************************************************
  // Decode
  // ***************************************************************
  frx_state_e state_reg;
  frx_state_e state_next;

  wire logic [5:0]            op6      = instr[FRX_INSTR_W-1:FRX_OP6_LSB];
  wire logic [3:0]            op4      = instr[FRX_INSTR_W-1:FRX_OP4_LSB];
  wire logic [2:0]            op3      = instr[FRX_INSTR_W-1:FRX_OP3_LSB];
  wire logic [FRX_ADDR_W-1:0] f_addr   = instr[FRX_F_MSB:FRX_F_LSB];
  wire logic                  dest_bit = instr[FRX_DEST_BIT];
  wire logic [DATA_W-1:0]     literal  = instr[FRX_K_MSB:0];
  wire logic [FRX_BR_W-1:0]   br_imm   = instr[FRX_BR_MSB:0];

  // The instruction slot after a skip or branch is consumed as a no-operation
  wire logic exec_en = instr_valid && (state_reg == FRX_ST_RUN);

  wire logic is_com    = exec_en && (op6 == FRX_OP_COMPLEMENT);
  wire logic is_dec    = exec_en && (op6 == FRX_OP_DECREMENT);
  wire logic is_decsz  = exec_en && (op6 == FRX_OP_DEC_SKIP);
  wire logic is_inc    = exec_en && (op6 == FRX_OP_INCREMENT);
  wire logic is_incsz  = exec_en && (op6 == FRX_OP_INC_SKIP);
  wire logic is_or_reg = exec_en && (op6 == FRX_OP_OR_REG);
  wire logic is_or_lit = exec_en && (op4 == FRX_OP_OR_LIT);
  wire logic is_branch = exec_en && (op3 == FRX_OP_BRANCH);

  // ***************************************************************
  // Arithmetic and logic results
  // ***************************************************************
  logic [DATA_W-1:0] res_com;

  // Complement is one inverter per data bit
  for (genvar b = 0; b < DATA_W; b++) begin : g_com
    assign res_com[b] = ~file_rdata[b];
  end

  // Limitation: file_rdata comes straight from the file, so a write issued
  // in one cycle is not seen by a read of the same register in the next;
  // the surrounding core must forward file_wdata_reg for that case.
  wire logic [DATA_W-1:0] res_dec  = file_rdata - FRX_ONE;
  wire logic [DATA_W-1:0] res_inc  = file_rdata + FRX_ONE;
  wire logic [DATA_W-1:0] res_orf  = acc_reg | file_rdata;
  wire logic [DATA_W-1:0] res_orl  = acc_reg | literal;

  wire logic [DATA_W-1:0] result =
      is_com                 ? res_com :
      (is_dec || is_decsz)   ? res_dec :
      (is_inc || is_incsz)   ? res_inc :
      is_or_reg              ? res_orf :
      res_orl;

  wire logic result_zero = (result == FRX_ZERO);

  // Instructions that carry a destination bit
  wire logic has_dest   = is_com   ||
                          is_dec   ||
                          is_decsz ||
                          is_inc   ||
                          is_incsz ||
                          is_or_reg;
  wire logic to_file    = has_dest && (dest_bit != FRX_DEST_ACC);
  wire logic to_acc     = (has_dest && (dest_bit == FRX_DEST_ACC)) || is_or_lit;
  // Skip forms and branch leave the flags untouched
  wire logic z_update   = is_com    ||
                          is_dec    ||
                          is_inc    ||
                          is_or_reg ||
                          is_or_lit;
  wire logic skip_hit   = (is_decsz || is_incsz) && result_zero;
  wire logic [FRX_PC_W-1:0] br_target = {status_page, br_imm};

  // ***************************************************************
  // Next register values
  // ***************************************************************
  // Registers hold unless their own instruction selects them
  wire logic [DATA_W-1:0] acc_next   = to_acc ? result : acc_reg;
  wire logic              zero_next  = z_update ? result_zero : zero_reg;
  wire logic              flush_next = (state_next == FRX_ST_FLUSH);

  // ***************************************************************
  // Sequencing
  // ***************************************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FRX_ST_RUN: begin
        if (skip_hit || is_branch) begin
          state_next = FRX_ST_FLUSH;
        end
      end
      FRX_ST_FLUSH: begin
        // Hold until the prefetched instruction actually arrives to be dropped
        if (instr_valid) begin
          state_next = FRX_ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= FRX_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ***************************************************************
  // Accumulator and zero flag
  // ***************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc_reg  <= FRX_ACC_RST;
      zero_reg <= 1'b0;
    end else begin
      acc_reg  <= acc_next;
      zero_reg <= zero_next;
    end
  end

  // ***************************************************************
  // File write port, branch target and squash indication
  // ***************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      file_we_reg    <= 1'b0;
      file_addr_reg  <= '0;
      file_wdata_reg <= FRX_ZERO;
      pc_load_reg    <= 1'b0;
      pc_target_reg  <= '0;
      squash_reg     <= 1'b0;
    end else begin
      file_we_reg <= to_file;
      pc_load_reg <= is_branch;
      squash_reg  <= flush_next;
      if (to_file) begin
        file_addr_reg  <= f_addr;
        file_wdata_reg <= result;
      end
      if (is_branch) begin
        pc_target_reg <= br_target;
      end
    end
  end

endmodule

// ### testbench/frx_exec_sva.sv
// Concurrent checks on the execute block ports
`timescale 1ns/10ps
module frx_exec_sva
  import frx_pkg::*;
#(
  parameter int unsigned DATA_W = FRX_DATA_W
) (
  input wire logic                   clk_sys,
  input wire logic                   srst,
  input wire logic                   instr_valid,
  input wire logic [FRX_INSTR_W-1:0] instr,
  input wire logic [DATA_W-1:0]      file_rdata,
  input wire logic [FRX_PAGE_W-1:0]  status_page,
  input wire logic [DATA_W-1:0]      acc_reg,
  input wire logic                   zero_reg,
  input wire logic                   file_we_reg,
  input wire logic [FRX_ADDR_W-1:0]  file_addr_reg,
  input wire logic [DATA_W-1:0]      file_wdata_reg,
  input wire logic                   pc_load_reg,
  input wire logic [FRX_PC_W-1:0]    pc_target_reg,
  input wire logic                   squash_reg
);
  // ***************
  // Properties
  // ***************
  wire logic tk = instr_valid && !squash_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_take(logic [5:0] op, logic d);
    tk && instr[11:6] == op && instr[5] == d;
  endsequence
  property p_comp;
    s_take(FRX_OP_COMPLEMENT, 1'b1) |=> file_we_reg && file_wdata_reg == ~$past(file_rdata)
      && file_addr_reg == $past(instr[4:0]);
  endproperty
  a_comp: assert property (p_comp) else $error("complement write wrong");
  property p_dec;
    s_take(FRX_OP_DECREMENT, 1'b0) |=> acc_reg == $past(file_rdata) - FRX_ONE && !file_we_reg
      && zero_reg == (acc_reg == FRX_ZERO);
  endproperty
  a_dec: assert property (p_dec) else $error("decrement to acc wrong");
  property p_decsk;
    s_take(FRX_OP_DEC_SKIP, 1'b0) |=> $stable(zero_reg)
      && squash_reg == ($past(file_rdata) == FRX_ONE);
  endproperty
  a_decsk: assert property (p_decsk) else $error("decrement skip wrong");
  property p_inc;
    s_take(FRX_OP_INCREMENT, 1'b1) |=> file_we_reg && file_wdata_reg == $past(file_rdata)
      + FRX_ONE && zero_reg == (file_wdata_reg == FRX_ZERO);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_incsk;
    s_take(FRX_OP_INC_SKIP, 1'b1) |=> file_we_reg && $stable(zero_reg)
      && squash_reg == (file_wdata_reg == FRX_ZERO);
  endproperty
  a_incsk: assert property (p_incsk) else $error("increment skip wrong");
  property p_br;
    tk && instr[11:9] == FRX_OP_BRANCH |=> pc_load_reg && squash_reg && $stable(zero_reg)
      && pc_target_reg == {$past(status_page), $past(instr[8:0])} ##1 !pc_load_reg;
  endproperty
  a_br: assert property (p_br) else $error("branch wrong");
  property p_orl;
    tk && instr[11:8] == FRX_OP_OR_LIT |=> zero_reg == (acc_reg == FRX_ZERO)
      && acc_reg == ($past(acc_reg) | $past(instr[7:0]));
  endproperty
  a_orl: assert property (p_orl) else $error("or literal wrong");
  property p_orw;
    s_take(FRX_OP_OR_REG, 1'b1) |=> file_we_reg && $stable(acc_reg)
      && file_wdata_reg == ($past(acc_reg) | $past(file_rdata));
  endproperty
  a_orw: assert property (p_orw) else $error("or register wrong");
  property p_drop;
    squash_reg && instr_valid |=> !file_we_reg && !pc_load_reg && $stable(acc_reg) && !squash_reg;
  endproperty
  a_drop: assert property (p_drop) else $error("discarded slot had effect");
endmodule
bind frx_exec frx_exec_sva #(.DATA_W(DATA_W)) i_frx_exec_sva (.*);

// ### testbench/frx_file_model.sv
// File register array answering the execute block
`timescale 1ns/10ps
module frx_file_model
  import frx_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic [FRX_ADDR_W-1:0] rd_addr,
  input  wire logic                  we,
  input  wire logic [FRX_ADDR_W-1:0] wr_addr,
  input  wire logic [FRX_DATA_W-1:0] wr_data,
  output logic      [FRX_DATA_W-1:0] rd_data
);
  logic [FRX_DATA_W-1:0] mem [32];
  // Read is combinational, as the block samples it in the execute cycle
  assign rd_data = mem[rd_addr];
  always @(posedge clk_sys) begin
    if (we) begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule

// ### testbench/file_reg_alu_skip_branch_exec_tb.sv
// Self-checking bench for the execute block
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module file_reg_alu_skip_branch_exec_tb;
  import frx_pkg::*;
  logic                   clk_sys, srst, instr_valid, zero_reg, file_we_reg, pc_load_reg, squash_reg;
  logic [FRX_INSTR_W-1:0] instr;
  logic [FRX_PAGE_W-1:0]  status_page;
  logic [7:0]             file_rdata, acc_reg, file_wdata_reg;
  logic [4:0]             file_addr_reg;
  logic [FRX_PC_W-1:0]    pc_target_reg;
  int                     fails = 0, num_checks = 0;
  frx_exec i_frx_exec (.*);
  frx_file_model i_frx_file_model (.clk_sys(clk_sys), .rd_addr(instr[4:0]), .we(file_we_reg),
    .wr_addr(file_addr_reg), .wr_data(file_wdata_reg), .rd_data(file_rdata));
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One instruction slot; outputs are settled when this returns, valid stays up
  task go(input logic [11:0] i);
    instr = i;
    instr_valid = 1'b1;
    @(posedge clk_sys);
    #1;
  endtask
  task t_comp_dec;
    i_frx_file_model.mem[3] = 8'h5A; i_frx_file_model.mem[4] = 8'h01;
    go({FRX_OP_COMPLEMENT, 1'b0, 5'h03}); `CHK("acc", 8'hA5, acc_reg)
    `CHK("we", 1'b0, file_we_reg)
    go({FRX_OP_COMPLEMENT, 1'b1, 5'h03}); `CHK("data", 8'hA5, file_wdata_reg)
    `CHK("addr", 5'h03, file_addr_reg)
    go({FRX_OP_DECREMENT, 1'b0, 5'h04}); `CHK("acc", 8'h00, acc_reg)
    `CHK("zero", 1'b1, zero_reg)
    $display("complement and decrement done");
  endtask
  task t_skip;
    i_frx_file_model.mem[4] = 8'h01; i_frx_file_model.mem[7] = 8'hFF;
    go({FRX_OP_OR_LIT, 8'h80}); `CHK("zero", 1'b0, zero_reg)
    go({FRX_OP_DEC_SKIP, 1'b0, 5'h04}); `CHK("acc", 8'h00, acc_reg)
    `CHK("zero", 1'b0, zero_reg)
    `CHK("squash", 1'b1, squash_reg)
    go({FRX_OP_INCREMENT, 1'b0, 5'h04}); `CHK("acc", 8'h00, acc_reg)
    `CHK("squash", 1'b0, squash_reg)
    go({FRX_OP_INC_SKIP, 1'b1, 5'h07}); `CHK("data", 8'h00, file_wdata_reg)
    `CHK("squash", 1'b1, squash_reg)
    go({FRX_OP_BRANCH, 9'h000}); `CHK("pc load", 1'b0, pc_load_reg)
    go({FRX_OP_INCREMENT, 1'b1, 5'h04}); `CHK("data", 8'h02, file_wdata_reg)
    $display("skip done");
  endtask
  task t_branch_or;
    status_page = 2'h2; i_frx_file_model.mem[2] = 8'h14;
    go({FRX_OP_BRANCH, 9'h1FF}); `CHK("target", 11'h5FF, pc_target_reg)
    `CHK("pc load", 1'b1, pc_load_reg)
    go({FRX_OP_OR_LIT, 8'h01}); `CHK("acc", 8'h00, acc_reg)
    go({FRX_OP_OR_LIT, 8'h00}); `CHK("zero", 1'b1, zero_reg)
    go({FRX_OP_OR_LIT, 8'h81}); `CHK("acc", 8'h81, acc_reg)
    go({FRX_OP_OR_REG, 1'b1, 5'h02}); `CHK("data", 8'h95, file_wdata_reg)
    go({FRX_OP_OR_REG, 1'b0, 5'h02}); `CHK("acc", 8'h95, acc_reg)
    $display("branch and or done");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000; fails++;
    close_out();
  end
  initial begin
    srst = 1'b1; instr_valid = 1'b0; instr = '0; status_page = '0;
    repeat (8) @(posedge clk_sys);
    #1; srst = 1'b0;
    `CHK("acc", FRX_ACC_RST, acc_reg)
    @(posedge clk_sys);
    #1;
    `CHK("squash", 1'b0, squash_reg)
    t_comp_dec();
    t_skip();
    t_branch_or();
    instr_valid = 1'b0;
    @(posedge clk_sys);
    #1;
    close_out();
  end
endmodule
